// ---- src/rsl_pkg.sv ----
package rsl_pkg;

    // ****************************************************************
    // strap encodings
    // ****************************************************************
    localparam logic FREQ_SEL_100MHZ  = 1'h0;
    localparam logic FREQ_SEL_133MHZ  = 1'h1;
    localparam logic ECC_STRAP_ENABLE = 1'h0;
    localparam logic QD_STRAP_DEPTH1  = 1'h0;

    // ****************************************************************
    // queue depths
    // ****************************************************************
    localparam int   QDEPTH_W         = 4;
    localparam logic [QDEPTH_W-1:0] QDEPTH_ONE = 4'h1;
    localparam logic [QDEPTH_W-1:0] QDEPTH_MAX = 4'h8;

    // ****************************************************************
    // reset values (used until the first capture)
    // ****************************************************************
    localparam logic FREQ_RST         = 1'h0;
    localparam logic ECC_STRAP_RST    = 1'h1;
    localparam logic QD_STRAP_RST     = 1'h0;

    typedef struct packed {
        logic freqSelect;
        logic eccStrap;
    } rsl_sys_straps_t;

endpackage : rsl_pkg

// ---- src/rsl_reset_strap_latch.sv ----
`timescale 1ns/1ps
// Summary of operation
// - at system reset release the frequency strap is latched, 0 for 100 MHz, 1 for 133 MHz.
// - the latched frequency strap is shown as a bit of the hub configuration register.
// - the queue depth strap is sampled when processor reset is released.
// - a low queue depth sample gives depth one and a high sample gives depth eight.
// - at depth eight the device puts no further limit on queued host transactions.
// - the device leaves the queue depth strap line undriven while processor reset is asserted.
// - the ECC enable strap is latched at system reset release.
// - a latched 0 enables ECC generation on the data ECC pins, a latched 1 disables it.
// - the latched ECC strap is shown as a bit of the host error control register.
module rsl_reset_strap_latch
(
    // clock and system reset (high while the system reset input is asserted)
    input  wire  logic                         mclk,
    input  wire  logic                         sys_rst,
    // processor reset, high while asserted
    input  wire  logic                         processorReset,
    // strap pins
    input  wire  logic                         freqSelectStrap,
    input  wire  logic                         eccEnableStrap,
    input  wire  logic                         queueDepthStrapIn,
    output logic                               queueDepthStrapOut,
    output logic                               queueDepthStrapOe,
    // latched configuration
    output logic                               hubCfgFreqBit,
    output logic                               hostErrCtlEccBit,
    output logic                               freqIs133,
    output logic                               eccGenEnable,
    output logic [rsl_pkg::QDEPTH_W-1:0]       inOrderQueueDepth,
    output logic                               queueLimitEnable
);

    // ****************************************************************
    // reset release detection
    // ****************************************************************
    // sys_rst clears this flag; first clocked edge after release captures
    logic                      sysCapDone_ff;
    logic                      nxt_sysCapDone;
    logic                      cpuRstPrev_ff;
    logic                      nxt_cpuRstPrev;
    rsl_pkg::rsl_sys_straps_t  sysStraps_ff;
    rsl_pkg::rsl_sys_straps_t  nxt_sysStraps;
    logic                      qdStrap_ff;
    logic                      nxt_qdStrap;
    logic                      cpuRstRise;

    // processor reset deasserting means its active-high input falls
    assign cpuRstRise = cpuRstPrev_ff && !processorReset;

    always_comb
    begin
        nxt_sysCapDone = 1'h1;
        nxt_sysStraps  = sysStraps_ff;
        nxt_cpuRstPrev = processorReset;
        nxt_qdStrap    = qdStrap_ff;
        if (!sysCapDone_ff)
        begin
            nxt_sysStraps.freqSelect = freqSelectStrap;
            nxt_sysStraps.eccStrap   = eccEnableStrap;
        end
        if (cpuRstRise)
        begin
            nxt_qdStrap = queueDepthStrapIn;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sysCapDone_ff <= 1'h0;
            sysStraps_ff  <= '{freqSelect: rsl_pkg::FREQ_RST, eccStrap: rsl_pkg::ECC_STRAP_RST};
            cpuRstPrev_ff <= 1'h0;
            qdStrap_ff    <= rsl_pkg::QD_STRAP_RST;
        end
        else
        begin
            sysCapDone_ff <= nxt_sysCapDone;
            sysStraps_ff  <= nxt_sysStraps;
            cpuRstPrev_ff <= nxt_cpuRstPrev;
            qdStrap_ff    <= nxt_qdStrap;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // never drive the queue depth line; the board owns it at reset
    // depth one relies on the board pulling low
    assign queueDepthStrapOut = 1'h0;
    assign queueDepthStrapOe  = 1'h0;

    // frequency bit for hub config register
    assign hubCfgFreqBit    = sysStraps_ff.freqSelect;
    assign freqIs133        = (sysStraps_ff.freqSelect == rsl_pkg::FREQ_SEL_133MHZ);
    // ECC bit for host error control register
    assign hostErrCtlEccBit = sysStraps_ff.eccStrap;
    assign eccGenEnable     = (sysStraps_ff.eccStrap == rsl_pkg::ECC_STRAP_ENABLE);
    assign inOrderQueueDepth = (qdStrap_ff == rsl_pkg::QD_STRAP_DEPTH1) ?
                               rsl_pkg::QDEPTH_ONE : rsl_pkg::QDEPTH_MAX;
    // no extra throttle at full depth
    assign queueLimitEnable  = (qdStrap_ff == rsl_pkg::QD_STRAP_DEPTH1);

    // ****************************************************************
    // checks
    // ****************************************************************
    // latch at release
    property p_freq_capture;
        @(posedge mclk) disable iff (sys_rst)
        !sysCapDone_ff |=> (hubCfgFreqBit == $past(freqSelectStrap));
    endproperty
    a_freq_capture: assert property (p_freq_capture) else $error("freq not latched");

    property p_freq_ratio;
        @(posedge mclk) disable iff (sys_rst)
        freqIs133 == hubCfgFreqBit;
    endproperty
    a_freq_ratio: assert property (p_freq_ratio) else $error("freq ratio mismatch");

    property p_qd_sample;
        @(posedge mclk) disable iff (sys_rst)
        cpuRstRise |=> (queueLimitEnable == !$past(queueDepthStrapIn));
    endproperty
    a_qd_sample: assert property (p_qd_sample) else $error("queue strap not sampled");

    property p_qd_depth;
        @(posedge mclk) disable iff (sys_rst)
        queueLimitEnable |-> inOrderQueueDepth == rsl_pkg::QDEPTH_ONE;
    endproperty
    a_qd_depth: assert property (p_qd_depth) else $error("depth one wrong");

    property p_qd_full;
        @(posedge mclk) disable iff (sys_rst)
        !queueLimitEnable |-> inOrderQueueDepth == rsl_pkg::QDEPTH_MAX;
    endproperty
    a_qd_full: assert property (p_qd_full) else $error("depth eight wrong");

    property p_qd_undriven;
        @(posedge mclk) disable iff (sys_rst)
        processorReset |-> !queueDepthStrapOe;
    endproperty
    a_qd_undriven: assert property (p_qd_undriven) else $error("queue strap driven");

    property p_ecc_capture;
        @(posedge mclk) disable iff (sys_rst)
        !sysCapDone_ff |=> (eccGenEnable == !$past(eccEnableStrap));
    endproperty
    a_ecc_capture: assert property (p_ecc_capture) else $error("ecc strap not latched");

    property p_ecc_reg;
        @(posedge mclk) disable iff (sys_rst)
        eccGenEnable != hostErrCtlEccBit;
    endproperty
    a_ecc_reg: assert property (p_ecc_reg) else $error("ecc bit mismatch");

    property p_hold;
        @(posedge mclk) disable iff (sys_rst)
        sysCapDone_ff |=> $stable(hubCfgFreqBit) && $stable(hostErrCtlEccBit);
    endproperty
    a_hold: assert property (p_hold) else $error("latched strap changed");

    property p_qd_hold;
        @(posedge mclk) disable iff (sys_rst)
        !cpuRstRise |=> $stable(inOrderQueueDepth);
    endproperty
    a_qd_hold: assert property (p_qd_hold) else $error("queue depth changed");

    // ****************************************************************
    // multi-step checks
    // ****************************************************************
    // processor reset held, then released on the next edge
    sequence s_cpu_release;
        processorReset ##1 !processorReset;
    endsequence

    // capture edge, then the first edge with the straps held
    sequence s_sys_capture;
        !sysCapDone_ff ##1 sysCapDone_ff;
    endsequence

    property p_ratio_cap;
        @(posedge mclk) disable iff (sys_rst)
        s_sys_capture |-> freqIs133 == ($past(freqSelectStrap) == rsl_pkg::FREQ_SEL_133MHZ);
    endproperty
    a_ratio_cap: assert property (p_ratio_cap) else $error("ratio not latched");

    property p_qd_depth_cap;
        @(posedge mclk) disable iff (sys_rst)
        s_cpu_release |=> inOrderQueueDepth ==
            (($past(queueDepthStrapIn) == rsl_pkg::QD_STRAP_DEPTH1) ?
             rsl_pkg::QDEPTH_ONE : rsl_pkg::QDEPTH_MAX);
    endproperty
    a_qd_depth_cap: assert property (p_qd_depth_cap) else $error("depth not sampled");

    property p_qd_limit_cap;
        @(posedge mclk) disable iff (sys_rst)
        s_cpu_release |=> queueLimitEnable ==
            ($past(queueDepthStrapIn) == rsl_pkg::QD_STRAP_DEPTH1);
    endproperty
    a_qd_limit_cap: assert property (p_qd_limit_cap) else $error("limit not sampled");

    property p_ecc_gen_cap;
        @(posedge mclk) disable iff (sys_rst)
        s_sys_capture |-> eccGenEnable == ($past(eccEnableStrap) == rsl_pkg::ECC_STRAP_ENABLE);
    endproperty
    a_ecc_gen_cap: assert property (p_ecc_gen_cap) else $error("ecc gen not latched");

    // no resample on cpu release
    // a processor reset alone must never disturb the system straps
    property p_sys_keep;
        @(posedge mclk) disable iff (sys_rst)
        s_cpu_release ##0 sysCapDone_ff |=>
            $stable(hubCfgFreqBit) && $stable(hostErrCtlEccBit);
    endproperty
    a_sys_keep: assert property (p_sys_keep) else $error("straps resampled");

endmodule : rsl_reset_strap_latch

// ---- dv/rsl_strap_board.sv ----
`timescale 1ns/1ps
// ****************************************************************
// board straps and host bus reset logic
// ****************************************************************
module rsl_strap_board
(
    // clock and processor reset
    input  wire logic mclk,
    input  wire logic processorReset,
    // scenario choices
    input  wire logic freqChoice,
    input  wire logic eccChoice,
    input  wire logic depthOneWanted,
    // strap pins
    input  wire logic queueDepthStrapOut,
    input  wire logic queueDepthStrapOe,
    output logic      freqSelectStrap,
    output logic      eccEnableStrap,
    output logic      queueDepthLine
);
    logic [1:0] holdCnt = 2'h0;
    // fixed board resistors, no pulls inside the device
    assign freqSelectStrap = freqChoice;
    assign eccEnableStrap  = eccChoice;
    always_ff @(posedge mclk)
        holdCnt <= processorReset ? 2'h2 : holdCnt - {1'b0, holdCnt != 2'h0};
    // termination pulls the line high when nobody drives it
    assign queueDepthLine = (depthOneWanted && (processorReset || holdCnt != 2'h0)) ? 1'h0
                          : queueDepthStrapOe ? queueDepthStrapOut : 1'h1;
endmodule : rsl_strap_board

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic       mclk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       processorReset = 1'b0;
    logic       freqChoice = 1'b0;
    logic       eccChoice = 1'b0;
    logic       depthOneWanted = 1'b0;
    logic       freqSelectStrap, eccEnableStrap, queueDepthLine, qdOut, qdOe;
    logic       hubCfgFreqBit, hostErrCtlEccBit, freqIs133, eccGenEnable, queueLimitEnable;
    logic [3:0] depth;
    int         bad_count = 0;
    int         check_count = 0;

    always #5 mclk = ~mclk;

    rsl_reset_strap_latch uut (.mclk(mclk), .sys_rst(sys_rst), .processorReset(processorReset),
        .freqSelectStrap(freqSelectStrap), .eccEnableStrap(eccEnableStrap),
        .queueDepthStrapIn(queueDepthLine), .queueDepthStrapOut(qdOut),
        .queueDepthStrapOe(qdOe), .hubCfgFreqBit(hubCfgFreqBit),
        .hostErrCtlEccBit(hostErrCtlEccBit), .freqIs133(freqIs133),
        .eccGenEnable(eccGenEnable), .inOrderQueueDepth(depth),
        .queueLimitEnable(queueLimitEnable));

    rsl_strap_board board (.mclk(mclk), .processorReset(processorReset),
        .freqChoice(freqChoice), .eccChoice(eccChoice), .depthOneWanted(depthOneWanted),
        .queueDepthStrapOut(qdOut), .queueDepthStrapOe(qdOe),
        .freqSelectStrap(freqSelectStrap), .eccEnableStrap(eccEnableStrap),
        .queueDepthLine(queueDepthLine));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_queue;
        logic hi;
        for (int k = 0; k < 3; k++)
        begin
            hi = (k != 1);
            depthOneWanted = !hi;
            processorReset = 1'b1;
            for (int c = 0; c < 4; c++)
            begin
                step(1);
                chk({3'h0, qdOe}, 4'h0);
            end
            processorReset = 1'b0;
            step(3);
            // line is back high here, so a late resample would show
            chk(depth, hi ? 4'h8 : 4'h1);
            chk({3'h0, queueLimitEnable}, {3'h0, !hi});
            step(4);
            chk(depth, hi ? 4'h8 : 4'h1);
        end
        $display("test_queue done");
    endtask : test_queue

    task automatic test_reset_defaults;
        // latch 133 MHz first so the reset default is visible
        freqChoice = 1'h1;
        sys_rst = 1'h1;
        step(2);
        sys_rst = 1'h0;
        step(2);
        chk({3'h0, hubCfgFreqBit}, 4'h1);
        sys_rst = 1'h1;
        step(2);
        chk({3'h0, hubCfgFreqBit}, 4'h0);
        chk({3'h0, freqIs133}, 4'h0);
        chk({3'h0, hostErrCtlEccBit}, 4'h1);
        chk({3'h0, eccGenEnable}, 4'h0);
        chk(depth, 4'h1);
        chk({3'h0, queueLimitEnable}, 4'h1);
        chk({3'h0, qdOe}, 4'h0);
        chk({3'h0, qdOut}, 4'h0);
        $display("test_reset_defaults done");
    endtask : test_reset_defaults

    task automatic test_sys_straps;
        logic [1:0] v;
        for (int i = 0; i < 4; i++)
        begin
            v = i[1:0];
            freqChoice = v[0];
            eccChoice = v[1];
            sys_rst = 1'b1;
            step(2);
            sys_rst = 1'b0;
            step(2);
            for (int r = 0; r < 2; r++)
            begin
                chk({3'h0, hubCfgFreqBit}, {3'h0, v[0]});
                chk({3'h0, freqIs133}, {3'h0, v[0]});
                chk({3'h0, hostErrCtlEccBit}, {3'h0, v[1]});
                chk({3'h0, eccGenEnable}, {3'h0, !v[1]});
                freqChoice = !v[0];
                eccChoice = !v[1];
                step(3);
            end
        end
        $display("test_sys_straps done");
    endtask : test_sys_straps

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    initial
    begin
        step(16);
        sys_rst = 1'b0;
        step(2);
        test_queue();
        test_reset_defaults();
        test_sys_straps();
        stop_test();
    end
endmodule : tb
